// ### logic/hdse_regs.svh
// Purpose: Constants for the serial video stream encoder
// Assumes: Included by bare name from the design files
// Notes:   Slot counts are in multiplexed words, word counts per stream
`ifndef HDSE_REGS_SVH
`define HDSE_REGS_SVH

// Words per line in each unmultiplexed stream
`define HDSE_M_30      12'd2200
`define HDSE_M_25      12'd2640
`define HDSE_M_24      12'd2750
// Line blanking per unmultiplexed stream
`define HDSE_K_30      12'd280
`define HDSE_K_25      12'd720
`define HDSE_K_24      12'd830
// Ancillary or blanking region per unmultiplexed stream
`define HDSE_N_30      12'd268
`define HDSE_N_25      12'd708
`define HDSE_N_24      12'd728
// Line length in the multiplexed stream
`define HDSE_MS_30     13'd4400
`define HDSE_MS_25     13'd5280
`define HDSE_MS_24     13'd5500
// Line blanking in the multiplexed stream
`define HDSE_KS_30     13'd560
`define HDSE_KS_25     13'd1440
`define HDSE_KS_24     13'd1660
// Ancillary or blanking region in the multiplexed stream
`define HDSE_NS_30     13'd536
`define HDSE_NS_25     13'd1416
`define HDSE_NS_24     13'd1456
// First multiplexed slot of the ancillary region (after 8 words per stream)
`define HDSE_ANC_SLOT  13'd16

// Word positions after the end marker
`define HDSE_W_LIDX_LO 12'd4
`define HDSE_W_LIDX_HI 12'd5
`define HDSE_W_CK0     12'd6
`define HDSE_W_CK1     12'd7

// Fixed word values
`define HDSE_MARK_ONE  10'h3ff
`define HDSE_MARK_ZERO 10'h000
`define HDSE_BLANK_Y   10'h040
`define HDSE_BLANK_C   10'h200
`define HDSE_CHECK     10'h200

// Frame structure
`define HDSE_LINES     11'd1125
`define HDSE_ACT_FIRST 11'd42
`define HDSE_ACT_LAST  11'd1121

// Serializer
`define HDSE_BITS_LAST 4'd9
`endif

// ### logic/hdse_pkg.sv
// Purpose: Types shared by the serial video stream encoder
// Assumes: Nothing beyond the constants header
// Notes:   Enumerations carry no explicit codes
`default_nettype none
package hdse_pkg;
  typedef logic [9:0] hdse_word_t;
  typedef enum logic [1:0] {HDSE_FAM_30, HDSE_FAM_25, HDSE_FAM_24} hdse_fam_e;
  typedef enum logic {GEN_FILL, GEN_WAIT} hdse_gen_e;
endpackage : hdse_pkg
`default_nettype wire

// ### logic/hdse_word_if.sv
// Purpose: Word hand-off between the word domain and the bit domain
// Assumes: Toggle handshake; word held stable while toggles differ
// Notes:   put_tgl is owned by the word domain, ack_tgl by the bit domain
`timescale 1ns/1ps
`default_nettype none
interface hdse_word_if;
  import hdse_pkg::*;
  hdse_word_t word;     // Multiplexed word on offer
  logic       put_tgl;  // Flips when a new word is offered
  logic       ack_tgl;  // Flips when the word was taken
  modport src (output word, output put_tgl, input ack_tgl);
  modport ser (input word, input put_tgl, output ack_tgl);
endinterface : hdse_word_if
`default_nettype wire

// ### logic/hdse_bit_serializer.sv
// Purpose: Serialize words LSB first, scramble and apply NRZI coding
// Assumes: sclk is the serial bit clock, unrelated to the word clock
// Notes:   Scrambler state is cleared only by reset, never per word
`timescale 1ns/1ps
`default_nettype none
`include "hdse_regs.svh"
module hdse_bit_serializer import hdse_pkg::*; (
  input  wire logic sclk,      // Serial bit clock
  input  wire logic rst_n,     // Asynchronous reset, active low
  hdse_word_if.ser  wif,       // Word hand-off from the word domain
  output logic      ser_out,   // NRZI line level
  output logic      underrun   // No word was ready at a word boundary
);
  logic       srst_m_r;
  logic       srst_n_r;
  logic       put_m1_r;
  logic       put_s_r;
  logic       ack_r,   ack_nxt;
  logic [9:0] sh_r,    sh_nxt;
  logic [3:0] cnt_r,   cnt_nxt;
  logic [8:0] lfsr_r,  lfsr_nxt;
  logic       nrzi_r,  nrzi_nxt;
  logic       under_r, under_nxt;
  logic       data_bit;
  logic       scr_bit;

  // Reset release synchronized to the bit clock
  always_ff @(posedge sclk or negedge rst_n) begin
    if (!rst_n) begin
      srst_m_r <= 1'b0;
      srst_n_r <= 1'b0;
    end else begin
      srst_m_r <= 1'b1;
      srst_n_r <= srst_m_r;
    end
  end

  // Offer toggle crosses on two flops; only put_s_r is read
  always_ff @(posedge sclk or negedge srst_n_r) begin
    if (!srst_n_r) begin
      put_m1_r <= 1'b0;
      put_s_r  <= 1'b0;
    end else begin
      put_m1_r <= wif.put_tgl;
      put_s_r  <= put_m1_r;
    end
  end

  // Shift, scramble and code; the chain runs through every word boundary
  always_comb begin
    data_bit  = sh_r[0];
    scr_bit   = data_bit ^ lfsr_r[8] ^ lfsr_r[3];
    lfsr_nxt  = {lfsr_r[7:0], scr_bit};
    nrzi_nxt  = nrzi_r ^ scr_bit;
    ack_nxt   = ack_r;
    under_nxt = under_r;
    if (cnt_r == `HDSE_BITS_LAST) begin
      cnt_nxt = 4'h0;
      if (put_s_r != ack_r) begin
        sh_nxt    = wif.word;
        ack_nxt   = ~ack_r;
        under_nxt = 1'b0;
      end else begin
        // Underrun keeps the line coded so the far end stays locked
        sh_nxt    = 10'h000;
        under_nxt = 1'b1;
      end
    end else begin
      cnt_nxt = cnt_r + 4'h1;
      sh_nxt  = {1'b0, sh_r[9:1]};
    end
  end

  always_ff @(posedge sclk or negedge srst_n_r) begin
    if (!srst_n_r) begin
      ack_r   <= 1'b0;
      sh_r    <= 10'h000;
      cnt_r   <= `HDSE_BITS_LAST;
      lfsr_r  <= 9'h000;
      nrzi_r  <= 1'b0;
      under_r <= 1'b0;
    end else begin
      ack_r   <= ack_nxt;
      sh_r    <= sh_nxt;
      cnt_r   <= cnt_nxt;
      lfsr_r  <= lfsr_nxt;
      nrzi_r  <= nrzi_nxt;
      under_r <= under_nxt;
    end
  end

  // One line bit per rising sclk edge, so the line rate is exactly the bit clock's rate
  assign wif.ack_tgl = ack_r;
  assign ser_out     = nrzi_r;
  assign underrun    = under_r;

  // Checks on the bit domain
  property p_word_wrap;
    @(posedge sclk) disable iff (!srst_n_r)
    (cnt_r == 4'd9) |=> (cnt_r == 4'd0) ##9 (cnt_r == 4'd9);
  endproperty
  a_word_wrap: assert property (p_word_wrap) else $error("bit count not ten per word");

  property p_lsb_first;
    @(posedge sclk) disable iff (!srst_n_r)
    (cnt_r == 4'd9 && put_s_r != ack_r) |=> (data_bit == $past(wif.word[0]))
      ##9 (data_bit == $past(wif.word[9], 10));
  endproperty
  a_lsb_first: assert property (p_lsb_first) else $error("word not sent LSB first");

  property p_nrzi;
    @(posedge sclk) disable iff (!srst_n_r)
    ##1 ((ser_out != $past(ser_out)) == $past(scr_bit));
  endproperty
  a_nrzi: assert property (p_nrzi) else $error("line toggle does not follow one bits");

  property p_scramble;
    @(posedge sclk) disable iff (!srst_n_r)
    ##1 (lfsr_r[0] == $past(scr_bit) && lfsr_r[4] == $past(lfsr_r[3]));
  endproperty
  a_scramble: assert property (p_scramble) else $error("scrambler history broken");

  c_underrun: cover property (@(posedge sclk) disable iff (!srst_n_r) $rose(under_r));
  c_ack:      cover property (@(posedge sclk) disable iff (!srst_n_r) ack_r != $past(ack_r));
endmodule : hdse_bit_serializer
`default_nettype wire

// ### logic/hdse_stream_encoder.sv
// Purpose: Build Y and colour streams, multiplex and send them serially
// Assumes: Video words arrive on mclk; sclk is the serial bit clock
// Notes:   Word pace follows the bit clock through a toggle handshake
`timescale 1ns/1ps
`default_nettype none
`include "hdse_regs.svh"
module hdse_stream_encoder import hdse_pkg::*; (
  input  wire logic        mclk,           // Word clock
  input  wire logic        rst_n,          // Asynchronous reset, active low
  input  wire logic        sclk,           // Serial bit clock
  input  wire logic [1:0]  fam_sel,        // System family pin: 0 30/60, 1 25/50, 2+ 24
  input  wire logic [9:0]  vid_luma,       // Luma word for the current sample pair
  input  wire logic [9:0]  vid_chroma,     // Colour word for the current sample pair
  output logic             vid_take,       // Both video words taken this cycle
  output logic [10:0]      line_index,     // Line being sent
  output logic             ser_out,        // Serial NRZI output, sclk domain
  output logic             link_underrun   // Bit domain ran dry, sclk domain
);
  hdse_word_if wif ();

  hdse_gen_e   st_r,     st_nxt;
  hdse_fam_e   fam_r,    fam_nxt;
  hdse_fam_e   fam_pin;
  logic [1:0]  fam_m1_r;
  logic [1:0]  fam_m2_r;
  logic [12:0] slot_r,   slot_nxt;
  logic [10:0] line_r,   line_nxt;
  hdse_word_t  hold_r,   hold_nxt;
  logic        put_r,    put_nxt;
  hdse_word_t  keep_r,   keep_nxt;
  logic        ack_m1_r;
  logic        ack_s_r;

  logic [12:0] ms_last;
  logic [12:0] ks;
  logic [12:0] ns;
  logic [11:0] m_last;
  logic [11:0] ks_w;
  logic [11:0] w;
  logic        chroma_slot;
  logic        active;
  logic        in_anc;
  logic        vblank;
  logic [9:0]  flags_end;
  logic [9:0]  flags_start;
  hdse_word_t  word;
  logic        fill;
  logic        advance;

  // Family pin and ack toggle cross on two flops before any use
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      fam_m1_r <= 2'h0;
      fam_m2_r <= 2'h0;
      ack_m1_r <= 1'b0;
      ack_s_r  <= 1'b0;
    end else begin
      fam_m1_r <= fam_sel;
      fam_m2_r <= fam_m1_r;
      ack_m1_r <= wif.ack_tgl;
      ack_s_r  <= ack_m1_r;
    end
  end

  // Pin decode; a family change takes effect only at a line boundary
  always_comb begin
    case (fam_m2_r)
      2'h0:    fam_pin = HDSE_FAM_30;
      2'h1:    fam_pin = HDSE_FAM_25;
      default: fam_pin = HDSE_FAM_24;
    endcase
  end

  // Line geometry of the selected family
  always_comb begin
    case (fam_r)
      HDSE_FAM_30: begin
        ms_last = `HDSE_MS_30 - 13'd1;
        ks      = `HDSE_KS_30;
        ns      = `HDSE_NS_30;
        m_last  = `HDSE_M_30 - 12'd1;
      end
      HDSE_FAM_25: begin
        ms_last = `HDSE_MS_25 - 13'd1;
        ks      = `HDSE_KS_25;
        ns      = `HDSE_NS_25;
        m_last  = `HDSE_M_25 - 12'd1;
      end
      default: begin
        ms_last = `HDSE_MS_24 - 13'd1;
        ks      = `HDSE_KS_24;
        ns      = `HDSE_NS_24;
        m_last  = `HDSE_M_24 - 12'd1;
      end
    endcase
  end

  // Two multiplexed slots make one stream word; even slot is colour
  assign w           = slot_r[12:1];
  assign ks_w        = ks[12:1];
  assign chroma_slot = ~slot_r[0];
  assign active      = (slot_r >= ks);
  assign in_anc      = (slot_r >= `HDSE_ANC_SLOT) && (slot_r < `HDSE_ANC_SLOT + ns);
  assign vblank      = (line_r < `HDSE_ACT_FIRST) || (line_r > `HDSE_ACT_LAST);
  // Timing flags: 1 F V H P3 P2 P1 P0 0 0, with F held at zero
  assign flags_end   = {1'b1, 1'b0, vblank, 1'b1, ~vblank, 1'b1, vblank, ~vblank, 2'b00};
  assign flags_start = {1'b1, 1'b0, vblank, 1'b0, vblank, 1'b0, vblank, vblank, 2'b00};

  // Word for the current slot; both streams share the same word layout
  always_comb begin
    if (active) begin
      word = chroma_slot ? vid_chroma : keep_r;
    end else if (w == 12'd0) begin
      word = `HDSE_MARK_ONE;
    end else if (w == 12'd1 || w == 12'd2) begin
      word = `HDSE_MARK_ZERO;
    end else if (w == 12'd3) begin
      word = flags_end;
    end else if (w == `HDSE_W_LIDX_LO) begin
      word = {~line_r[6], line_r[6:0], 2'b00};
    end else if (w == `HDSE_W_LIDX_HI) begin
      word = {1'b1, 3'b000, line_r[10:7], 2'b00};
    end else if (w == `HDSE_W_CK0 || w == `HDSE_W_CK1) begin
      word = `HDSE_CHECK;
    end else if (w == ks_w - 12'd4) begin
      word = `HDSE_MARK_ONE;
    end else if (w == ks_w - 12'd3 || w == ks_w - 12'd2) begin
      word = `HDSE_MARK_ZERO;
    end else if (w == ks_w - 12'd1) begin
      word = flags_start;
    end else begin
      // Ancillary region and any spare blanking carry blank levels
      word = chroma_slot ? `HDSE_BLANK_C : `HDSE_BLANK_Y;
    end
  end

  assign fill    = (st_r == GEN_FILL);
  assign advance = (st_r == GEN_WAIT) && (ack_s_r == put_r);

  // Word generator: offer one word, wait for the bit domain to take it
  always_comb begin
    st_nxt   = st_r;
    slot_nxt = slot_r;
    line_nxt = line_r;
    hold_nxt = hold_r;
    put_nxt  = put_r;
    keep_nxt = keep_r;
    fam_nxt  = fam_r;
    vid_take = 1'b0;
    case (st_r)
      GEN_FILL: begin
        hold_nxt = word;
        put_nxt  = ~put_r;
        st_nxt   = GEN_WAIT;
        if (active && chroma_slot) begin
          // Luma is parked for the following slot so both inputs go in one take
          vid_take = 1'b1;
          keep_nxt = vid_luma;
        end
      end
      GEN_WAIT: begin
        if (advance) begin
          st_nxt = GEN_FILL;
          if (slot_r == ms_last) begin
            slot_nxt = 13'h0000;
            fam_nxt  = fam_pin;
            line_nxt = (line_r == `HDSE_LINES) ? 11'h001 : line_r + 11'h001;
          end else begin
            slot_nxt = slot_r + 13'h0001;
          end
        end
      end
      default: begin
        st_nxt = GEN_FILL;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_r   <= GEN_FILL;
      fam_r  <= HDSE_FAM_25;
      slot_r <= 13'h0000;
      line_r <= 11'h001;
      hold_r <= 10'h000;
      put_r  <= 1'b0;
      keep_r <= 10'h000;
    end else begin
      st_r   <= st_nxt;
      fam_r  <= fam_nxt;
      slot_r <= slot_nxt;
      line_r <= line_nxt;
      hold_r <= hold_nxt;
      put_r  <= put_nxt;
      keep_r <= keep_nxt;
    end
  end

  assign wif.word    = hold_r;
  assign wif.put_tgl = put_r;
  assign line_index  = line_r;

  // Bit domain: twenty bits per stream word pair, scrambled and coded
  hdse_bit_serializer u_ser (
    .sclk     (sclk),
    .rst_n    (rst_n),
    .wif      (wif),
    .ser_out  (ser_out),
    .underrun (link_underrun)
  );

  // Checks on the word domain
  property p_end_head;
    @(posedge mclk) disable iff (!rst_n)
    (fill && w == 12'd0) |=> (hold_r == 10'h3ff);
  endproperty
  a_end_head: assert property (p_end_head) else $error("end marker does not open with 3ff");

  property p_start_zero;
    @(posedge mclk) disable iff (!rst_n)
    (fill && !active && (w == ks_w - 12'd3)) |=> (hold_r == 10'h000);
  endproperty
  a_start_zero: assert property (p_start_zero) else $error("start marker second word not zero");

  // Flag parity judged from the offered word itself, so a wrong flag expression is caught
  property p_flags_parity;
    @(posedge mclk) disable iff (!rst_n)
    (fill && !active && (w == 12'd3 || w == ks_w - 12'd1)) |=>
      hold_r[9] && (hold_r[1:0] == 2'b00)
      && (hold_r[5] == (hold_r[7] ^ hold_r[6]))
      && (hold_r[4] == (hold_r[8] ^ hold_r[6]))
      && (hold_r[3] == (hold_r[8] ^ hold_r[7]))
      && (hold_r[2] == (hold_r[8] ^ hold_r[7] ^ hold_r[6]));
  endproperty
  a_flags_parity: assert property (p_flags_parity) else $error("timing flags parity wrong");

  property p_line_words;
    @(posedge mclk) disable iff (!rst_n)
    (fill && w == 12'd4) |=> (hold_r[8:2] == $past(line_r[6:0])) && (hold_r[9] == ~hold_r[8]);
  endproperty
  a_line_words: assert property (p_line_words) else $error("line index word misplaced");

  property p_check_words;
    @(posedge mclk) disable iff (!rst_n)
    (fill && (w == 12'd6 || w == 12'd7)) |=> (hold_r == 10'h200);
  endproperty
  a_check_words: assert property (p_check_words) else $error("check word misplaced");

  property p_line_len;
    @(posedge mclk) disable iff (!rst_n)
    (advance && slot_r == ms_last) |-> (w == m_last) && (ms_last[12:1] == m_last)
      ##1 (slot_r == 13'h0000);
  endproperty
  a_line_len: assert property (p_line_len) else $error("line length wrong");

  property p_anc_blank;
    @(posedge mclk) disable iff (!rst_n)
    (fill && in_anc && !active) |=> (hold_r == (slot_r[0] ? 10'h040 : 10'h200));
  endproperty
  a_anc_blank: assert property (p_anc_blank) else $error("ancillary region not blank");

  property p_mux_order;
    @(posedge mclk) disable iff (!rst_n)
    (fill && active && chroma_slot) |-> vid_take
      ##1 (hold_r == $past(vid_chroma)) && (keep_r == $past(vid_luma));
  endproperty
  a_mux_order: assert property (p_mux_order) else $error("colour word not before luma");

  property p_active_luma;
    @(posedge mclk) disable iff (!rst_n)
    (fill && active && !chroma_slot) |=> (hold_r == $past(keep_r)) && !$past(vid_take);
  endproperty
  a_active_luma: assert property (p_active_luma) else $error("luma slot wrong");

  property p_hold_steady;
    @(posedge mclk) disable iff (!rst_n)
    (st_r == GEN_WAIT && ack_s_r != put_r) |=> $stable(hold_r) && $stable(put_r);
  endproperty
  a_hold_steady: assert property (p_hold_steady) else $error("offered word changed early");

  c_line_end:  cover property (@(posedge mclk) disable iff (!rst_n) advance && slot_r == ms_last);
  c_vid_take:  cover property (@(posedge mclk) disable iff (!rst_n) vid_take);
  c_fam_24:    cover property (@(posedge mclk) disable iff (!rst_n) fam_r == HDSE_FAM_24);
endmodule : hdse_stream_encoder
`default_nettype wire

// ### verification/hdse_rx_model.sv
// Purpose: Receiving end of the serial link: undo NRZI, descramble, align on markers
// Assumes: Bit taken at every rising sclk; ser_in changes just after sclk edges
// Notes:   Alignment follows every marker seen, so a slipped word shows as a bad value
`timescale 1ns/1ps
`default_nettype none
module hdse_rx_model import hdse_pkg::*; (
  input  wire logic sclk,     // Serial bit clock
  input  wire logic rst_n,    // Asynchronous reset, active low
  input  wire logic ser_in,   // NRZI line level
  output hdse_word_t rx_word, // Recovered multiplexed word
  output logic      rx_stb,   // One sclk pulse per recovered word
  output logic      rx_lock   // A marker has been found
);
  logic        prev_r;   // Last line level
  logic [8:0]  hist_r;   // Scrambled bit history, newest in bit 0
  logic [29:0] win_r;    // Last three words of descrambled bits
  logic [3:0]  cnt_r;    // Bits since the last word boundary
  logic        dat;
  logic        bit_d;
  logic [29:0] win_nxt;

  // A level change means a scrambled one; then the self-synchronizing descrambler
  always_comb begin
    dat     = ser_in ^ prev_r;
    bit_d   = dat ^ hist_r[3] ^ hist_r[8];
    win_nxt = {bit_d, win_r[29:1]};
  end

  // Word framing; a marker pins the boundary, counting keeps it between markers
  always_ff @(posedge sclk or negedge rst_n) begin
    if (!rst_n) begin
      prev_r  <= 1'b0;
      hist_r  <= 9'h000;
      win_r   <= 30'h0;
      cnt_r   <= 4'h0;
      rx_stb  <= 1'b0;
      rx_lock <= 1'b0;
      rx_word <= 10'h000;
    end else begin
      prev_r  <= ser_in;
      hist_r  <= {hist_r[7:0], dat};
      win_r   <= win_nxt;
      rx_word <= win_nxt[29:20];
      rx_stb  <= rx_lock && (cnt_r == 4'h9);
      cnt_r   <= (cnt_r == 4'h9) ? 4'h0 : cnt_r + 4'h1;
      if (win_nxt == {10'h000, 10'h000, 10'h3ff}) begin
        cnt_r   <= 4'h0;
        rx_lock <= 1'b1;
      end
    end
  end
endmodule : hdse_rx_model
`default_nettype wire

// ### verification/tb_top.sv
// Purpose: Self-checking bench for the serial video stream encoder
// Assumes: Line 1 runs 25/50 from reset; the pin then selects 30/60 for line 2
// Notes:   Line 1 from slot 4 on and line 2 up to its first active pair are checked
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import hdse_pkg::*;
  localparam int KS  = 1440; // Multiplexed line blanking
  localparam int MS  = 5280; // Multiplexed line length
  localparam int NS  = 1416; // Multiplexed ancillary region
  localparam int OFS = 4;    // Queue entry 0 is slot 4: the model locks inside the first marker
  localparam int KS30 = 560; // Multiplexed line blanking, 30/60 family
  localparam int NS30 = 536; // Multiplexed ancillary region, 30/60 family
  logic        mclk;
  logic        sclk;
  logic        rst_n;
  logic [1:0]  fam_sel;
  hdse_word_t  vid_luma;
  hdse_word_t  vid_chroma;
  logic        vid_take;
  logic [10:0] line_index;
  logic        ser_out;
  logic        link_underrun;
  hdse_word_t  rx_word;
  logic        rx_stb;
  logic        rx_lock;
  hdse_word_t  rx_q[$];
  int          pair_k;
  int          err_count;
  int          cmp_count;

  hdse_stream_encoder hdse_stream_encoder_i (.mclk(mclk), .rst_n(rst_n), .sclk(sclk),
    .fam_sel(fam_sel), .vid_luma(vid_luma), .vid_chroma(vid_chroma), .vid_take(vid_take),
    .line_index(line_index), .ser_out(ser_out), .link_underrun(link_underrun));
  hdse_rx_model hdse_rx_model_i (.sclk(sclk), .rst_n(rst_n), .ser_in(ser_out),
    .rx_word(rx_word), .rx_stb(rx_stb), .rx_lock(rx_lock));

  // Word clock
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // Link clock, offset so its edges never coincide with mclk edges
  initial begin
    sclk = 1'b0;
    #3.3;
    forever #7.5 sclk = ~sclk;
  end

  // Sample values never hit the marker codes, so the receiver cannot lock on video
  function automatic hdse_word_t vid_val(int k, logic luma);
    return 10'(32'h10 + k % 900 + (luma ? 32'h40 : 32'h0));
  endfunction : vid_val
  function automatic hdse_word_t flags(logic v, logic h);
    return {1'b1, 1'b0, v, h, v ^ h, h, v, v ^ h, 2'b00};
  endfunction : flags
  // Expected word in a blanking slot; even slots colour, odd slots luma
  function automatic hdse_word_t exp_slot(int s, logic [10:0] ln, int blk, int anc);
    if (s < 8) return (s < 2) ? 10'h3ff : (s < 6) ? 10'h000 : flags(1'b1, 1'b1);
    if (s < 10) return {~ln[6], ln[6:0], 2'b00};
    if (s < 12) return {1'b1, 3'b000, ln[10:7], 2'b00};
    if (s < 16) return 10'h200;
    if (s < 16 + anc || s < blk - 8) return s[0] ? 10'h040 : 10'h200;
    if (s < blk - 2) return (s < blk - 6) ? 10'h3ff : 10'h000;
    return flags(1'b1, 1'b0);
  endfunction : exp_slot

  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : test_done
  task automatic chk_word(hdse_word_t got, hdse_word_t exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_word
  task automatic chk_num(logic [31:0] got, logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_num
  // Bounded wait for recovered words; running out ends the run
  task automatic wait_words(int n);
    int i;
    for (i = 0; i < 85000 && rx_q.size() < n; i++) @(posedge mclk);
    if (rx_q.size() < n) begin
      err_count++;
      test_done();
    end
  endtask : wait_words

  // Collect recovered words
  always @(posedge sclk) begin
    if (rx_stb === 1'b1) rx_q.push_back(rx_word);
  end
  // Offer the next sample pair once the current one is taken
  always @(posedge mclk) begin
    if (vid_take === 1'b1) begin
      pair_k     <= pair_k + 1;
      vid_chroma <= vid_val(pair_k + 1, 1'b0);
      vid_luma   <= vid_val(pair_k + 1, 1'b1);
    end
  end

  // Outputs sit at their idle values while reset is held
  task automatic sc_reset();
    repeat (10) @(posedge mclk);
    chk_num(32'(vid_take), 32'h0);
    chk_num(32'(line_index), 32'h1);
    chk_num(32'(ser_out), 32'h0);
    chk_num(32'(link_underrun), 32'h0);
    rst_n <= 1'b1;
  endtask : sc_reset
  // Line 1 header, ancillary fill and start marker, slot by slot
  task automatic sc_header();
    int s;
    wait_words(KS - OFS);
    chk_num(32'(rx_lock), 32'h1);
    for (s = OFS; s < KS; s++) begin
      chk_word(rx_q[s - OFS], exp_slot(s, 11'h1, KS, NS));
    end
    chk_num(32'(line_index), 32'h1);
    // Pin moves mid-line; line 1 must keep the 25/50 geometry to its end
    fam_sel <= 2'h0;
  endtask : sc_header
  // Active words in order, then line length via the next end marker
  task automatic sc_active();
    int k;
    wait_words(MS + 16 - OFS);
    for (k = 0; k < 1920; k++) begin
      chk_word(rx_q[KS - OFS + 2 * k], vid_val(k, 1'b0));
      chk_word(rx_q[KS - OFS + 2 * k + 1], vid_val(k, 1'b1));
    end
    chk_num(32'(pair_k), 32'd1920);
    for (k = 0; k < 16; k++) begin
      chk_word(rx_q[MS - OFS + k], exp_slot(k, 11'h2, KS30, NS30));
    end
    chk_num(32'(line_index), 32'h2);
    chk_num(32'(link_underrun), 32'h0);
  endtask : sc_active
  // Line 2 in the 30/60 family: shorter blanking, then the first active pair
  task automatic sc_fam30();
    int s;
    wait_words(MS + KS30 + 2 - OFS);
    for (s = 16; s < KS30; s++) begin
      chk_word(rx_q[MS - OFS + s], exp_slot(s, 11'h2, KS30, NS30));
    end
    chk_word(rx_q[MS - OFS + KS30], vid_val(1920, 1'b0));
    chk_word(rx_q[MS - OFS + KS30 + 1], vid_val(1920, 1'b1));
    chk_num(32'(line_index), 32'h2);
  endtask : sc_fam30

  // Main sequence
  initial begin
    err_count  = 0;
    cmp_count  = 0;
    pair_k     = 0;
    rst_n      = 1'b0;
    fam_sel    = 2'h1;
    vid_chroma = vid_val(0, 1'b0);
    vid_luma   = vid_val(0, 1'b1);
    sc_reset();
    sc_header();
    sc_active();
    sc_fam30();
    test_done();
  end
endmodule : tb_top
`default_nettype wire
